/* File: supervisor_pkg.sv */
// Overview of operation
// R01: reset output low while any rail is under voltage or manual reset held low.
// R02: reset held 200 ms after all causes clear; new cause restarts the hold.
// R03: overvoltage output low while any rail reports over voltage.
// R04: overvoltage output stays low 25 us after all rails drop back below threshold.
// R05: watchdog output low when no strobe edge arrives within the active timeout.
// R06: rising and falling strobe edges both restart the watchdog count.
// R07: watchdog output released as soon as a strobe edge is seen.
// R08: host holds each strobe level at least 50 ns.
// R09: manual reset accepted after 1 us low; glitches of 100 ns or less ignored.
// R10: margin low freezes reset output against rail and watchdog changes.
// R11: margin freeze wins over a simultaneous manual reset.
// R12: floating manual reset and margin read high, floating strobe reads low.
// R13: system should loop watchdog output back into manual reset input.
// R14: all three outputs are active low open drain, only pulling low.
// R15: initial watchdog period after power-up and each reset release, normal afterwards.
// R16: async inputs synchronised before use; all timeouts are clock cycle counts.
package supervisor_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned RESET_HOLD_MS    = 200;
    localparam int unsigned OV_HOLD_US       = 25;
    localparam int unsigned MR_ACCEPT_NS     = 1000;
    localparam int unsigned STROBE_MIN_NS    = 50;
    localparam int unsigned WD_INIT_MS       = 102400;
    localparam int unsigned WD_NORM_MS       = 1600;
    localparam longint unsigned RESET_HOLD_CYC = longint'(RESET_HOLD_MS) * 1000 * CLK_MHZ;
    localparam int unsigned OV_HOLD_CYC      = OV_HOLD_US * CLK_MHZ;
    // least time rounds up
    localparam int unsigned MR_ACCEPT_CYC    = (MR_ACCEPT_NS * CLK_MHZ + 999) / 1000;
    localparam longint unsigned WD_INIT_CYC  = longint'(WD_INIT_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned WD_NORM_CYC  = longint'(WD_NORM_MS) * 1000 * CLK_MHZ;
    localparam int unsigned NUM_RAILS        = 6;
    localparam int unsigned CNT_W            = 36;
endpackage

/* File: input_sync.sv */
`timescale 1ns/100ps
module input_sync
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // R16: two stage synchroniser
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

/* File: supply_supervisor.sv */
`timescale 1ns/100ps
module supply_supervisor
    import supervisor_pkg::*;
#(
    parameter int unsigned    RAILS        = NUM_RAILS,
    parameter longint unsigned RESET_HOLD  = RESET_HOLD_CYC,
    parameter int unsigned    OV_HOLD      = OV_HOLD_CYC,
    parameter int unsigned    MR_ACCEPT    = MR_ACCEPT_CYC,
    parameter longint unsigned WD_INIT     = WD_INIT_CYC,
    parameter longint unsigned WD_NORM     = WD_NORM_CYC
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // comparators, high = fault
    input  wire logic [RAILS-1:0] i_rail_under,
    input  wire logic [RAILS-1:0] i_rail_over,
    // host pins, floated pins resolved outside
    input  wire logic             i_manual_reset_n,
    input  wire logic             i_margin_n,
    input  wire logic             i_watchdog_strobe,
    // R14: open drain enables, high pulls low
    output logic                  o_system_reset_oe,
    output logic                  o_overvoltage_flag_oe,
    output logic                  o_watchdog_expired_oe
);
    localparam int unsigned SYNC_W = 2 * RAILS + 3;

    logic [SYNC_W-1:0] sync_s;
    logic [RAILS-1:0]  under_s;
    logic [RAILS-1:0]  over_s;
    logic              mr_n_s;
    logic              margin_n_s;
    logic              strobe_s;
    logic              strobe_q;
    logic              strobe_edge;
    logic [15:0]       mr_cnt_q;
    logic              mr_ok_q;
    logic              cause;
    logic [CNT_W-1:0]  rst_cnt_q;
    logic [15:0]       ov_cnt_q;
    logic [CNT_W-1:0]  wd_cnt_q;
    logic              wd_normal_q;
    logic              rst_was_q;

    /////////////////////////////////////////////////////////////////////////
    // R12: floated manual reset and margin idle high, strobe idles low
    input_sync
    #(
        .WIDTH     (SYNC_W),
        .RESET_VAL ({{(2 * RAILS){1'b0}}, 3'b110})
    )
    u_sync
    (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_rail_under, i_rail_over, i_manual_reset_n, i_margin_n, i_watchdog_strobe}),
        .o_sync  (sync_s)
    );

    assign under_s    = sync_s[2*RAILS+2:RAILS+3];
    assign over_s     = sync_s[RAILS+2:3];
    assign mr_n_s     = sync_s[2];
    assign margin_n_s = sync_s[1];
    assign strobe_s   = sync_s[0];

    /////////////////////////////////////////////////////////////////////////
    // R09: manual reset low filter
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mr_cnt_q <= 16'h0000;
            mr_ok_q  <= 1'b0;
        end
        else if (mr_n_s)
        begin
            mr_cnt_q <= 16'h0000;
            mr_ok_q  <= 1'b0;
        end
        else if (mr_cnt_q < 16'(MR_ACCEPT - 1))
        begin
            mr_cnt_q <= mr_cnt_q + 16'h0001;
        end
        else
        begin
            mr_ok_q <= 1'b1;
        end
    end

    // R09: glitch rejection check
    chk_mr_glitch: assert property (@(posedge i_clk) disable iff (i_reset) // R09
        $rose(mr_ok_q) |-> !$past(mr_n_s) && !$past(mr_n_s, 8))
        else $error("manual reset glitch accepted");

    /////////////////////////////////////////////////////////////////////////
    // R01: reset cause
    assign cause = (|under_s) | mr_ok_q;

    // R02: reset stretch, R10: margin freeze, R11: margin over manual reset
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            rst_cnt_q         <= '0;
            o_system_reset_oe <= 1'b1;
        end
        else if (!margin_n_s)
        begin
            o_system_reset_oe <= o_system_reset_oe;
        end
        else if (cause)
        begin
            rst_cnt_q         <= '0;
            o_system_reset_oe <= 1'b1;
        end
        else if (o_system_reset_oe)
        begin
            if (rst_cnt_q >= CNT_W'(RESET_HOLD - 1))
            begin
                o_system_reset_oe <= 1'b0;
            end
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end
    end

    // R01 R02 R10 R11: reset output checks
    chk_rst_cause: assert property (@(posedge i_clk) disable iff (i_reset) // R01
        (cause && margin_n_s) |=> o_system_reset_oe)
        else $error("reset not asserted on cause");
    chk_rst_hold: assert property (@(posedge i_clk) disable iff (i_reset) // R02
        $fell(cause) && margin_n_s && $past(margin_n_s) |-> o_system_reset_oe [*8])
        else $error("reset released early");
    chk_margin_freeze: assert property (@(posedge i_clk) disable iff (i_reset) // R10
        !margin_n_s |=> $stable(o_system_reset_oe))
        else $error("reset changed during margin");
    chk_margin_mr: assert property (@(posedge i_clk) disable iff (i_reset) // R11
        (!margin_n_s && mr_ok_q && !o_system_reset_oe) |=> !o_system_reset_oe)
        else $error("manual reset beat margin");

    /////////////////////////////////////////////////////////////////////////
    // R03: overvoltage assert, R04: 25 us release delay
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ov_cnt_q              <= 16'h0000;
            o_overvoltage_flag_oe <= 1'b0;
        end
        else if (|over_s)
        begin
            ov_cnt_q              <= 16'h0000;
            o_overvoltage_flag_oe <= 1'b1;
        end
        else if (o_overvoltage_flag_oe)
        begin
            if (ov_cnt_q >= 16'(OV_HOLD - 1))
            begin
                o_overvoltage_flag_oe <= 1'b0;
            end
            ov_cnt_q <= ov_cnt_q + 16'h0001;
        end
    end

    // R03 R04: overvoltage checks
    chk_ov_assert: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (|over_s) |=> o_overvoltage_flag_oe)
        else $error("overvoltage not asserted");
    chk_ov_hold: assert property (@(posedge i_clk) disable iff (i_reset) // R04
        $fell(|over_s) |-> o_overvoltage_flag_oe [*8])
        else $error("overvoltage released early");

    /////////////////////////////////////////////////////////////////////////
    // R06: both strobe edges service
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            strobe_q <= 1'b0;
        end
        else
        begin
            strobe_q <= strobe_s;
        end
    end

    assign strobe_edge = strobe_s ^ strobe_q;

    // R15: initial period until first edge after reset release
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wd_normal_q <= 1'b0;
            rst_was_q   <= 1'b1;
        end
        else
        begin
            rst_was_q <= o_system_reset_oe;
            if (rst_was_q && !o_system_reset_oe)
            begin
                wd_normal_q <= 1'b0;
            end
            else if (strobe_edge)
            begin
                wd_normal_q <= 1'b1;
            end
        end
    end

    // R05: timeout, R07: release on edge
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wd_cnt_q              <= '0;
            o_watchdog_expired_oe <= 1'b0;
        end
        else if (strobe_edge || (rst_was_q && !o_system_reset_oe))
        begin
            wd_cnt_q              <= '0;
            o_watchdog_expired_oe <= 1'b0;
        end
        else if (wd_cnt_q >= CNT_W'((wd_normal_q ? WD_NORM : WD_INIT) - 1))
        begin
            o_watchdog_expired_oe <= 1'b1;
        end
        else
        begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    // R07: watchdog release check
    chk_wd_release: assert property (@(posedge i_clk) disable iff (i_reset) // R07
        strobe_edge |=> !o_watchdog_expired_oe && wd_cnt_q == '0)
        else $error("watchdog not released on edge");

endmodule

/* File: supervisor_host_model.sv */
`timescale 1ns/100ps
module supervisor_host_model
(
    // clock and strobe request
    input  wire logic i_clk,
    input  wire logic i_kick,
    // open drain enables
    input  wire logic i_system_reset_oe,
    input  wire logic i_overvoltage_flag_oe,
    input  wire logic i_watchdog_expired_oe,
    // resolved lines
    output logic      o_reset_line_n,
    output logic      o_ov_line_n,
    output logic      o_wd_line_n,
    output logic      o_watchdog_strobe
);
    assign o_reset_line_n = i_system_reset_oe ? 1'b0 : 1'b1;
    assign o_ov_line_n    = i_overvoltage_flag_oe ? 1'b0 : 1'b1;
    assign o_wd_line_n    = i_watchdog_expired_oe ? 1'b0 : 1'b1;

    // strobe idles low, level held until next request
    initial o_watchdog_strobe = 1'b0;
    always @(posedge i_clk)
    begin
        if (i_kick)
        begin
            o_watchdog_strobe <= ~o_watchdog_strobe;
        end
    end
endmodule

/* File: supply_supervisor_tb_top.sv */
`timescale 1ns/100ps
module supply_supervisor_tb_top;
    logic            clk;
    logic            rst;
    logic            mr_n;
    logic            margin_n;
    logic            kick;
    logic [5:0]      under;
    logic [5:0]      over;
    wire logic       rst_oe;
    wire logic       ov_oe;
    wire logic       wd_oe;
    wire logic       strobe;
    wire logic [2:0] line;
    int              fails = 0;
    int              checked = 0;
    // under, over, expected reset, expected overvoltage
    localparam logic [13:0] ROWS [6] = '{{6'h01, 6'h00, 2'b10}, {6'h20, 6'h00, 2'b10}, {6'h00, 6'h01, 2'b01},
                                         {6'h00, 6'h20, 2'b01}, {6'h04, 6'h08, 2'b11}, {6'h00, 6'h00, 2'b00}};

    supply_supervisor #(.RESET_HOLD(20), .OV_HOLD(10), .MR_ACCEPT(10), .WD_INIT(100), .WD_NORM(40)) u_dut
    (
        .i_clk                 (clk),
        .i_reset               (rst),
        .i_rail_under          (under),
        .i_rail_over           (over),
        .i_manual_reset_n      (mr_n),
        .i_margin_n            (margin_n),
        .i_watchdog_strobe     (strobe),
        .o_system_reset_oe     (rst_oe),
        .o_overvoltage_flag_oe (ov_oe),
        .o_watchdog_expired_oe (wd_oe)
    );

    supervisor_host_model u_host
    (
        .i_clk                 (clk),
        .i_kick                (kick),
        .i_system_reset_oe     (rst_oe),
        .i_overvoltage_flag_oe (ov_oe),
        .i_watchdog_expired_oe (wd_oe),
        .o_reset_line_n        (line[0]),
        .o_ov_line_n           (line[1]),
        .o_wd_line_n           (line[2]),
        .o_watchdog_strobe     (strobe)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input int sel, input logic exp);
        checked++;
        if (line[sel] !== exp)
        begin
            fails++;
            $display("[ERR] %0t line %0d got %h exp %h", $time, sel, line[sel], exp);
        end
    endtask

    task automatic wait_line(input int sel, input logic val, input int lim);
        int n;
        n = 0;
        while (line[sel] !== val && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk(sel, val);
        if (line[sel] !== val)
            test_done();
    endtask

    task automatic strobe_edge;
        kick = 1'b1;
        @(negedge clk);
        kick = 1'b0;
        wait_line(2, 1'b1, 8);
    endtask

    task automatic follow(input int cyc);
        repeat (cyc)
        begin
            @(negedge clk);
            mr_n = line[2];
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, mr_n, margin_n, kick, under, over} = {4'b1110, 12'h000};
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk(0, 1'b0);
        wait_line(0, 1'b1, 40);
        $display("test power-up done");
        foreach (ROWS[r])
        begin
            {under, over} = ROWS[r][13:2];
            repeat (6) @(negedge clk);
            chk(0, ~ROWS[r][1]);
            chk(1, ~ROWS[r][0]);
            {under, over} = 12'h000;
            repeat (8) @(negedge clk);
            chk(1, ~ROWS[r][0]);
            chk(0, ~ROWS[r][1]);
            repeat (8) @(negedge clk);
            chk(1, 1'b1);
            wait_line(0, 1'b1, 30);
            $display("test row %0d done", r);
        end
        mr_n = 1'b0;
        repeat (4) @(negedge clk);
        mr_n = 1'b1;
        repeat (8) @(negedge clk);
        chk(0, 1'b1);
        mr_n = 1'b0;
        repeat (16) @(negedge clk);
        chk(0, 1'b0);
        mr_n = 1'b1;
        repeat (10) @(negedge clk);
        under = 6'h02;
        repeat (4) @(negedge clk);
        under = 6'h00;
        repeat (18) @(negedge clk);
        chk(0, 1'b0);
        wait_line(0, 1'b1, 20);
        $display("test manual reset done");
        repeat (85) @(negedge clk);
        chk(2, 1'b1);
        wait_line(2, 1'b0, 30);
        strobe_edge();
        repeat (30) @(negedge clk);
        chk(2, 1'b1);
        wait_line(2, 1'b0, 20);
        strobe_edge();
        $display("test watchdog done");
        margin_n = 1'b0;
        repeat (4) @(negedge clk);
        {mr_n, under, over} = {1'b0, 6'h10, 6'h10};
        repeat (20) @(negedge clk);
        chk(0, 1'b1);
        chk(1, 1'b0);
        {mr_n, under, over} = 13'h1000;
        repeat (4) @(negedge clk);
        margin_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(0, 1'b1);
        $display("test margin done");
        // expired watchdog looped into manual reset
        chk(2, 1'b0);
        follow(20);
        chk(0, 1'b0);
        strobe_edge();
        follow(10);
        chk(0, 1'b0);
        wait_line(0, 1'b1, 20);
        // initial period again after reset release
        repeat (60) @(negedge clk);
        chk(2, 1'b1);
        wait_line(2, 1'b0, 50);
        $display("test loopback done");
        test_done();
    end
endmodule
